// >>> src/mac_ctrl_pkg.sv
// shared constants and carrier types for the mac hash, phy management and pause block
package mac_ctrl_pkg;
    // clock and timing
    localparam int unsigned CLK_MHZ         = 250;
    localparam int unsigned MDC_HALF_NS     = 200;
    localparam int unsigned MDC_HALF_CYC    = (MDC_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SLOT_NS         = 5120;
    localparam int unsigned SLOT_CYC        = (SLOT_NS * CLK_MHZ + 999) / 1000;
    // register indices, byte address is four times the index
    localparam logic [5:0]  IDX_AUX_CTRL    = 6'h01;
    localparam logic [5:0]  IDX_HASH_UPPER  = 6'h04;
    localparam logic [5:0]  IDX_HASH_LOWER  = 6'h05;
    localparam logic [5:0]  IDX_PHY_ACCESS  = 6'h06;
    localparam logic [5:0]  IDX_PHY_DATA    = 6'h07;
    localparam logic [5:0]  IDX_PAUSE_FLOW  = 6'h08;
    localparam logic [31:0] REG_RESET       = 32'h00000000;
    // phy_mgmt_access fields
    localparam int unsigned ACC_BUSY_BIT    = 0;
    localparam int unsigned ACC_WNR_BIT     = 1;
    localparam int unsigned ACC_REG_LSB     = 6;
    localparam int unsigned ACC_PHY_LSB     = 11;
    localparam logic [31:0] ACC_WR_MASK     = 32'h0000FFC2;
    // pause_flow_control fields
    localparam int unsigned FLOW_BUSY_BIT   = 0;
    localparam int unsigned FLOW_EN_BIT     = 1;
    localparam int unsigned FLOW_PASS_BIT   = 2;
    localparam int unsigned FLOW_PT_LSB     = 16;
    localparam logic [31:0] FLOW_WR_MASK    = 32'hFFFF0006;
    // auxiliary control fields
    localparam int unsigned AUX_MCALL_BIT   = 0;
    localparam int unsigned AUX_FDX_BIT     = 1;
    localparam int unsigned AUX_TXEN_BIT    = 2;
    localparam int unsigned AUX_HALT_BIT    = 8;
    localparam logic [31:0] AUX_WR_MASK     = 32'h00000007;
    // management frame layout
    localparam logic [5:0]  MD_LAST_BIT     = 6'd63;
    localparam logic [5:0]  MD_TA_BIT       = 6'd46;
    localparam logic [5:0]  MD_DATA_BIT     = 6'd48;
    localparam logic [31:0] MD_PREAMBLE     = 32'hFFFFFFFF;
    localparam logic [1:0]  MD_START        = 2'b01;
    localparam logic [1:0]  MD_OP_WRITE     = 2'b01;
    localparam logic [1:0]  MD_OP_READ      = 2'b10;
    localparam logic [1:0]  MD_TA_WRITE     = 2'b10;
    // group address hash
    localparam logic [31:0] CRC_POLY        = 32'h04C11DB7;
    localparam logic [31:0] CRC_INIT        = 32'hFFFFFFFF;
    // ahb transfer types
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'b10;

    // group filter verdict, one pulse per looked-up address
    typedef struct packed {
        logic valid;
        logic accept;
    } hash_result_t;

    // pause frame request towards the transmitter
    typedef struct packed {
        logic        send;
        logic [15:0] time_val;
    } pause_tx_t;
endpackage : mac_ctrl_pkg

// >>> src/mac_hash_mii_flow_control.sv
// multicast hash filter, phy management engine and pause flow control with ahb-lite registers
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps

module mac_hash_mii_flow_control
(
    input  wire  logic                      ref_clk_in,
    input  wire  logic                      nrst_in,
    // ahb-lite slave
    input  wire  logic                      hsel_in,
    input  wire  logic [31:0]               haddr_in,
    input  wire  logic [1:0]                htrans_in,
    input  wire  logic                      hwrite_in,
    input  wire  logic [2:0]                hsize_in,
    input  wire  logic [31:0]               hwdata_in,
    input  wire  logic                      hready_in,
    output logic                            hreadyout_out,
    output logic [31:0]                     hrdata_out,
    output logic                            hresp_out,
    // receive address lookup
    input  wire  logic                      rx_addr_valid_in,
    input  wire  logic [47:0]               rx_dest_addr_in,
    output mac_ctrl_pkg::hash_result_t      rx_hash_out,
    // receive frames and pause detection
    input  wire  logic                      rx_frame_valid_in,
    input  wire  logic                      rx_pause_valid_in,
    input  wire  logic [15:0]               rx_pause_quanta_in,
    output logic                            rx_frame_forward_out,
    output logic                            rx_pause_flag_out,
    // transmit side pause control
    input  wire  logic                      pause_request_in,
    input  wire  logic                      pause_tx_done_in,
    input  wire  logic                      backpressure_request_in,
    output mac_ctrl_pkg::pause_tx_t         pause_tx_out,
    output logic                            backpressure_out,
    output logic                            tx_halt_out,
    // phy management pins
    output logic                            mdc_out,
    input  wire  logic                      mdio_in,
    output logic                            mdio_out,
    output logic                            mdio_oe_out
);
    import mac_ctrl_pkg::*;

    typedef enum logic {MD_IDLE, MD_SHIFT} md_state_t;

    // crc over the address, first byte in bits 7:0, each byte lsb first
    function automatic logic [5:0] hash_index(input logic [47:0] addr);
        logic [31:0] crc;
        crc = CRC_INIT;
        for (int i = 0; i < 48; i++)
        begin
            crc = (crc[31] ^ addr[i]) ? ((crc << 1) ^ CRC_POLY) : (crc << 1);
        end
        return crc[31:26];
    endfunction : hash_index

    // register state
    logic [31:0]  hash_upper_r, hash_upper_nxt;
    logic [31:0]  hash_lower_r, hash_lower_nxt;
    logic [31:0]  access_r,     access_nxt;
    logic [15:0]  data_r,       data_nxt;
    logic [31:0]  flow_r,       flow_nxt;
    logic [2:0]   aux_r,        aux_nxt;
    logic         wr_pend_r,    wr_pend_nxt;
    logic [5:0]   wr_idx_r,     wr_idx_nxt;
    logic [31:0]  hrdata_r,     hrdata_nxt;
    logic         md_start;
    // management engine state
    md_state_t    md_state_r,   md_state_nxt;
    logic [5:0]   div_r,        div_nxt;
    logic [5:0]   bit_r,        bit_nxt;
    logic [63:0]  frame_r,      frame_nxt;
    logic [15:0]  rdat_r,       rdat_nxt;
    logic         md_write_r,   md_write_nxt;
    logic         md_done_r,    md_done_nxt;
    logic         mdc_r,        mdc_nxt;
    logic         mdo_r,        mdo_nxt;
    logic         oe_r,         oe_nxt;
    logic         mdio_meta_r,  mdio_sync_r;
    // flow state
    logic         send_r,       send_nxt;
    logic         bp_r,         bp_nxt;
    logic [15:0]  quanta_r,     quanta_nxt;
    logic [10:0]  slot_r,       slot_nxt;
    logic         pflag_r,      pflag_nxt;
    logic         fwd_r,        fwd_nxt;
    hash_result_t hash_r,       hash_nxt;
    logic         pause_busy;
    logic         full_duplex;
    logic         tx_enable;
    logic         pause_enable;
    logic [63:0]  hash_table;

    assign full_duplex  = aux_r[AUX_FDX_BIT];
    assign tx_enable    = aux_r[AUX_TXEN_BIT];
    assign pause_enable = flow_r[FLOW_EN_BIT];
    assign hash_table   = {hash_upper_r, hash_lower_r};

    // register file: writes in the data phase, read data staged from next values
    always_comb
    begin
        hash_upper_nxt = hash_upper_r;
        hash_lower_nxt = hash_lower_r;
        access_nxt     = access_r;
        data_nxt       = data_r;
        flow_nxt       = flow_r;
        aux_nxt        = aux_r;
        md_start       = 1'b0;
        hrdata_nxt     = 32'h00000000;
        if (wr_pend_r)
        begin
            case (wr_idx_r)
                IDX_AUX_CTRL:   aux_nxt = hwdata_in[2:0];
                IDX_HASH_UPPER: hash_upper_nxt = hwdata_in;
                IDX_HASH_LOWER: hash_lower_nxt = hwdata_in;
                IDX_PHY_ACCESS:
                    if (!access_r[ACC_BUSY_BIT])
                    begin
                        access_nxt = (hwdata_in & ACC_WR_MASK)
                                   | {31'h00000000, hwdata_in[ACC_BUSY_BIT]};
                        md_start   = hwdata_in[ACC_BUSY_BIT];
                    end
                IDX_PHY_DATA:
                    if (!access_r[ACC_BUSY_BIT])
                    begin
                        data_nxt = hwdata_in[15:0];
                    end
                IDX_PAUSE_FLOW: flow_nxt = hwdata_in & FLOW_WR_MASK;
                default: ;
            endcase
        end
        // engine finished: busy drops, read result lands in the data register
        if (md_done_r)
        begin
            access_nxt[ACC_BUSY_BIT] = 1'b0;
            if (!md_write_r)
            begin
                data_nxt = rdat_r;
            end
        end
        if (hsel_in && hready_in && htrans_in == HTRANS_NONSEQ && !hwrite_in)
        begin
            case (haddr_in[7:2])
                IDX_AUX_CTRL:   hrdata_nxt = {23'h000000, tx_halt_out, 5'h00, aux_nxt};
                IDX_HASH_UPPER: hrdata_nxt = hash_upper_nxt;
                IDX_HASH_LOWER: hrdata_nxt = hash_lower_nxt;
                IDX_PHY_ACCESS: hrdata_nxt = access_nxt;
                IDX_PHY_DATA:   hrdata_nxt = {16'h0000, data_nxt};
                IDX_PAUSE_FLOW: hrdata_nxt = {flow_nxt[31:1], pause_busy};
                default:        hrdata_nxt = 32'h00000000;
            endcase
        end
        wr_pend_nxt = hsel_in && hready_in && htrans_in == HTRANS_NONSEQ && hwrite_in;
        wr_idx_nxt  = haddr_in[7:2];
    end

    // register file flops
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            hash_upper_r <= REG_RESET;
            hash_lower_r <= REG_RESET;
            access_r     <= REG_RESET;
            data_r       <= REG_RESET[15:0];
            flow_r       <= REG_RESET;
            aux_r        <= REG_RESET[2:0];
            wr_pend_r    <= 1'b0;
            wr_idx_r     <= 6'h00;
            hrdata_r     <= REG_RESET;
        end
        else
        begin
            hash_upper_r <= hash_upper_nxt;
            hash_lower_r <= hash_lower_nxt;
            access_r     <= access_nxt;
            data_r       <= data_nxt;
            flow_r       <= flow_nxt;
            aux_r        <= aux_nxt;
            wr_pend_r    <= wr_pend_nxt;
            wr_idx_r     <= wr_idx_nxt;
            hrdata_r     <= hrdata_nxt;
        end
    end

    assign hreadyout_out = 1'b1;    // zero wait states
    assign hresp_out     = 1'b0;    // always okay
    assign hrdata_out    = hrdata_r;

    // management frame engine: drive on mdc fall, sample on mdc rise
    always_comb
    begin
        md_state_nxt = md_state_r;
        div_nxt      = div_r;
        bit_nxt      = bit_r;
        frame_nxt    = frame_r;
        rdat_nxt     = rdat_r;
        md_write_nxt = md_write_r;
        md_done_nxt  = 1'b0;
        mdc_nxt      = mdc_r;
        mdo_nxt      = mdo_r;
        oe_nxt       = oe_r;
        case (md_state_r)
            MD_IDLE:
                if (md_start)
                begin
                    md_write_nxt = hwdata_in[ACC_WNR_BIT];
                    frame_nxt    = {MD_PREAMBLE, MD_START,
                                    hwdata_in[ACC_WNR_BIT] ? MD_OP_WRITE : MD_OP_READ,
                                    hwdata_in[ACC_PHY_LSB +: 5],
                                    hwdata_in[ACC_REG_LSB +: 5],
                                    MD_TA_WRITE, data_r};
                    bit_nxt      = 6'd0;
                    div_nxt      = 6'd0;
                    mdc_nxt      = 1'b0;
                    mdo_nxt      = 1'b1;
                    oe_nxt       = 1'b1;
                    md_state_nxt = MD_SHIFT;
                end
            MD_SHIFT:
                if (div_r == 6'(MDC_HALF_CYC - 1))
                begin
                    div_nxt = 6'd0;
                    mdc_nxt = !mdc_r;
                    if (!mdc_r)
                    begin
                        if (!md_write_r && bit_r >= MD_DATA_BIT)
                        begin
                            rdat_nxt = {rdat_r[14:0], mdio_sync_r};
                        end
                    end
                    else if (bit_r == MD_LAST_BIT)
                    begin
                        md_done_nxt  = 1'b1;
                        oe_nxt       = 1'b0;
                        mdo_nxt      = 1'b0;
                        md_state_nxt = MD_IDLE;
                    end
                    else
                    begin
                        bit_nxt   = bit_r + 6'd1;
                        frame_nxt = {frame_r[62:0], 1'b0};
                        mdo_nxt   = frame_r[62];
                        oe_nxt    = md_write_r || (bit_r + 6'd1 < MD_TA_BIT);
                    end
                end
                else
                begin
                    div_nxt = div_r + 6'd1;
                end
            default: md_state_nxt = MD_IDLE;
        endcase
    end

    // management engine flops and input synchroniser
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            md_state_r  <= MD_IDLE;
            div_r       <= 6'd0;
            bit_r       <= 6'd0;
            frame_r     <= 64'h0000000000000000;
            rdat_r      <= 16'h0000;
            md_write_r  <= 1'b0;
            md_done_r   <= 1'b0;
            mdc_r       <= 1'b0;
            mdo_r       <= 1'b0;
            oe_r        <= 1'b0;
            mdio_meta_r <= 1'b0;
            mdio_sync_r <= 1'b0;
        end
        else
        begin
            md_state_r  <= md_state_nxt;
            div_r       <= div_nxt;
            bit_r       <= bit_nxt;
            frame_r     <= frame_nxt;
            rdat_r      <= rdat_nxt;
            md_write_r  <= md_write_nxt;
            md_done_r   <= md_done_nxt;
            mdc_r       <= mdc_nxt;
            mdo_r       <= mdo_nxt;
            oe_r        <= oe_nxt;
            mdio_meta_r <= mdio_in;
            mdio_sync_r <= mdio_meta_r;
        end
    end

    assign mdc_out     = mdc_r;
    assign mdio_out    = mdo_r;
    assign mdio_oe_out = oe_r;

    // pause generation, back pressure, receive halt and group filter
    always_comb
    begin
        send_nxt = send_r;
        if (!tx_enable || !full_duplex)
        begin
            send_nxt = 1'b0;
        end
        else if (send_r && pause_tx_done_in)
        begin
            send_nxt = 1'b0;
        end
        else if (!send_r && pause_request_in)
        begin
            send_nxt = 1'b1;
        end
        bp_nxt = !full_duplex && pause_enable && tx_enable
               && backpressure_request_in;
        quanta_nxt = quanta_r;
        slot_nxt   = slot_r;
        if (pause_enable && full_duplex && rx_pause_valid_in)
        begin
            quanta_nxt = rx_pause_quanta_in;
            slot_nxt   = 11'(SLOT_CYC - 1);
        end
        else if (quanta_r != 16'h0000)
        begin
            if (slot_r == 11'd0)
            begin
                quanta_nxt = quanta_r - 16'h0001;
                slot_nxt   = 11'(SLOT_CYC - 1);
            end
            else
            begin
                slot_nxt = slot_r - 11'd1;
            end
        end
        pflag_nxt = rx_pause_valid_in && flow_r[FLOW_PASS_BIT];
        fwd_nxt   = rx_frame_valid_in;
        hash_nxt.valid  = rx_addr_valid_in;
        hash_nxt.accept = !rx_dest_addr_in[0] || aux_r[AUX_MCALL_BIT]
                        || hash_table[hash_index(rx_dest_addr_in)];
    end

    // flow and filter flops
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            send_r   <= 1'b0;
            bp_r     <= 1'b0;
            quanta_r <= 16'h0000;
            slot_r   <= 11'd0;
            pflag_r  <= 1'b0;
            fwd_r    <= 1'b0;
            hash_r   <= '0;
        end
        else
        begin
            send_r   <= send_nxt;
            bp_r     <= bp_nxt;
            quanta_r <= quanta_nxt;
            slot_r   <= slot_nxt;
            pflag_r  <= pflag_nxt;
            fwd_r    <= fwd_nxt;
            hash_r   <= hash_nxt;
        end
    end

    assign pause_busy            = full_duplex ? send_r : bp_r;
    assign pause_tx_out.send     = send_r;
    assign pause_tx_out.time_val = flow_r[FLOW_PT_LSB +: 16];
    assign backpressure_out      = bp_r;
    assign tx_halt_out           = quanta_r != 16'h0000;
    assign rx_pause_flag_out     = pflag_r;
    assign rx_frame_forward_out  = fwd_r;
    assign rx_hash_out           = hash_r;
endmodule : mac_hash_mii_flow_control

// >>> verif/mac_hash_mii_flow_control_properties.sv
// concurrent checks on the lookup, receive and pause ports of the control block
`timescale 1ns/1ps
module mac_hash_mii_flow_control_properties
(
    input  wire  logic                      ref_clk_in,
    input  wire  logic                      nrst_in,
    input  wire  logic                      rx_addr_valid_in,
    input  wire  logic [47:0]               rx_dest_addr_in,
    input  wire  mac_ctrl_pkg::hash_result_t rx_hash_out,
    input  wire  logic                      rx_frame_valid_in,
    input  wire  logic                      rx_frame_forward_out,
    input  wire  logic                      rx_pause_valid_in,
    input  wire  logic                      rx_pause_flag_out,
    input  wire  logic                      tx_halt_out,
    input  wire  logic                      pause_request_in,
    input  wire  logic                      pause_tx_done_in,
    input  wire  mac_ctrl_pkg::pause_tx_t   pause_tx_out,
    input  wire  logic                      backpressure_request_in,
    input  wire  logic                      backpressure_out
);
    import mac_ctrl_pkg::*;
    // one clock domain, all checks idle in reset
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!nrst_in);

    // receive side answers
    hash_valid_a: assert property (rx_hash_out.valid == $past(rx_addr_valid_in))
        else $error("lookup result not one cycle after request");
    unicast_ok_a: assert property (rx_addr_valid_in && !rx_dest_addr_in[0] |=> rx_hash_out.accept)
        else $error("unicast address rejected");
    forward_all_a: assert property (rx_frame_forward_out == $past(rx_frame_valid_in))
        else $error("received frame not forwarded");
    flag_cause_a: assert property (rx_pause_flag_out |-> $past(rx_pause_valid_in))
        else $error("pause flag without pause frame");
    halt_cause_a: assert property ($rose(tx_halt_out) |-> $past(rx_pause_valid_in) || $past(rx_pause_valid_in, 2))
        else $error("halt without received pause");
    // transmit side pause and back pressure
    send_cause_a: assert property ($rose(pause_tx_out.send) |-> $past(pause_request_in))
        else $error("pause frame without request");
    send_done_a: assert property (pause_tx_out.send && pause_tx_done_in |=> !pause_tx_out.send)
        else $error("pause send stays after done");
    bp_cause_a: assert property (backpressure_out |-> $past(backpressure_request_in))
        else $error("back pressure without request");
    duplex_excl_a: assert property (!(pause_tx_out.send && backpressure_out))
        else $error("pause frame and back pressure together");
endmodule : mac_hash_mii_flow_control_properties

bind mac_hash_mii_flow_control mac_hash_mii_flow_control_properties u_props
(
    .ref_clk_in, .nrst_in, .rx_addr_valid_in, .rx_dest_addr_in, .rx_hash_out,
    .rx_frame_valid_in, .rx_frame_forward_out, .rx_pause_valid_in, .rx_pause_flag_out,
    .tx_halt_out, .pause_request_in, .pause_tx_done_in, .pause_tx_out,
    .backpressure_request_in, .backpressure_out
);

// >>> verif/mac_hash_mii_flow_control_tb.sv
// self-checking bench for the hash filter, phy management and pause registers
`timescale 1ns/1ps
module mac_hash_mii_flow_control_tb;
    import mac_ctrl_pkg::*;
    logic         ref_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, pdone = 1'b0;
    logic         rxa_v = 1'b0, rxf_v = 1'b0, rxp_v = 1'b0, preq = 1'b0, bpreq = 1'b0;
    logic [1:0]   htrans = 2'h0;
    logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [47:0]  rx_da = 48'h0;
    logic [15:0]  rxp_q = 16'h0;
    logic         hrdy, hresp, pflag, bp, halt, mdc, mdo, mdoe, pmo, pmoe, mdio_ln;
    hash_result_t hres;
    pause_tx_t    ptx;
    logic [63:0]  frame;
    int           nfr, error_cnt = 0, n_tests = 0;

    always #2 ref_clk = ~ref_clk;
    // management line with pull-up when nobody drives
    assign mdio_ln = mdoe ? mdo : (pmoe ? pmo : 1'b1);

    mac_hash_mii_flow_control dut
    (
        .ref_clk_in(ref_clk), .nrst_in(nrst), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hrdy), .hreadyout_out(hrdy), .hrdata_out(hrdata), .hresp_out(hresp),
        .rx_addr_valid_in(rxa_v), .rx_dest_addr_in(rx_da), .rx_hash_out(hres),
        .rx_frame_valid_in(rxf_v), .rx_pause_valid_in(rxp_v), .rx_pause_quanta_in(rxp_q),
        .rx_frame_forward_out(), .rx_pause_flag_out(pflag), .pause_request_in(preq),
        .pause_tx_done_in(pdone), .backpressure_request_in(bpreq), .pause_tx_out(ptx),
        .backpressure_out(bp), .tx_halt_out(halt), .mdc_out(mdc), .mdio_in(mdio_ln),
        .mdio_out(mdo), .mdio_oe_out(mdoe)
    );
    phy_mgmt_model phy
    (
        .mdc_in(mdc), .mdio_in(mdio_ln), .mdio_out(pmo), .mdio_oe_out(pmoe),
        .frame_out(frame), .nframes_out(nfr)
    );

    // closing report
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t %s: %h vs %h", $time, m, got, exp);
        end
    endtask : chk
    // one single ahb-lite transfer, read data left in q
    task automatic bus(input logic w, input logic [5:0] i, input logic [31:0] d);
        haddr <= {24'h0, i, 2'b00};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        hsel <= 1'b1;
        do @(posedge ref_clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hrdy !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic rd(input logic [5:0] i, input logic [31:0] e, input string m);
        bus(1'b0, i, 32'h0);
        chk({hresp, q}, {1'b0, e}, m);
    endtask : rd
    // wait until the management engine is idle
    task automatic poll();
        int n = 0;
        do
        begin
            bus(1'b0, IDX_PHY_ACCESS, 32'h0);
            n++;
        end
        while (q[ACC_BUSY_BIT] !== 1'b0 && n < 8000);
        chk(64'(q[ACC_BUSY_BIT]), 64'h0, "busy stuck");
    endtask : poll
    // crc-32 over the address, first byte lsb first, top six bits
    function automatic logic [5:0] hidx(input logic [47:0] a);
        logic [31:0] c;
        c = CRC_INIT;
        for (int k = 0; k < 48; k++)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ a[k]) ? CRC_POLY : 32'h0);
        return c[31:26];
    endfunction : hidx
    task automatic look(input logic [47:0] a, input logic e, input string m);
        rx_da <= a;
        rxa_v <= 1'b1;
        @(posedge ref_clk);
        rxa_v <= 1'b0;
        #1;
        chk(hres, {1'b1, e}, m);
        @(posedge ref_clk);
    endtask : look
    task automatic pause_rx(input logic [15:0] qn);
        rxp_q <= qn;
        rxp_v <= 1'b1;
        rxf_v <= 1'b1;
        @(posedge ref_clk);
        rxp_v <= 1'b0;
        rxf_v <= 1'b0;
        #1;
    endtask : pause_rx

    // watchdog
    initial
    begin
        #300000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict();
    end

    // main sequence
    initial
    begin
        logic [47:0] a;
        logic [63:0] hot;
        logic [5:0]  tg;
        int          n;
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rd(IDX_AUX_CTRL, 32'h0, "aux reset");
        for (int i = 4; i < 9; i++) rd(6'(i), 32'h0, "reset value");
        bus(1'b1, 6'h3F, 32'hFFFFFFFF);
        rd(6'h3F, 32'h0, "unmapped");
        $display("register test done");
        // boundary hash indices 0, 31, 32 and 63
        for (int t = 0; t < 4; t++)
        begin
            tg = 6'((t / 2) * 32 + (t % 2) * 31);
            a = 48'h1;
            while (hidx(a) !== tg) a = a + 48'h100;
            hot = 64'h1 << tg;
            bus(1'b1, IDX_HASH_UPPER, hot[63:32]);
            bus(1'b1, IDX_HASH_LOWER, hot[31:0]);
            look(a, 1'b1, "hash hit");
            bus(1'b1, IDX_HASH_UPPER, ~hot[63:32]);
            bus(1'b1, IDX_HASH_LOWER, ~hot[31:0]);
            rd(IDX_HASH_UPPER, ~hot[63:32], "upper word");
            look(a, 1'b0, "hash miss");
        end
        bus(1'b1, IDX_AUX_CTRL, 32'h1);
        look(a, 1'b1, "pass all");
        look({a[47:1], 1'b0}, 1'b1, "unicast");
        $display("hash test done");
        // phy write of register 9, refused data write, then read back
        bus(1'b1, IDX_PHY_DATA, 32'h00001234);
        bus(1'b1, IDX_PHY_ACCESS, 32'h00000A43);
        rd(IDX_PHY_ACCESS, 32'h00000A43, "busy set");
        bus(1'b1, IDX_PHY_DATA, 32'h00005555);
        rd(IDX_PHY_DATA, 32'h00001234, "data held");
        poll();
        chk(frame, {MD_PREAMBLE, MD_START, MD_OP_WRITE, 5'h01, 5'h09, MD_TA_WRITE, 16'h1234},
            "write frame");
        chk(64'(nfr), 64'h1, "one frame");
        bus(1'b1, IDX_PHY_DATA, 32'h0000FFFF);
        bus(1'b1, IDX_PHY_ACCESS, 32'h00000A41);
        poll();
        rd(IDX_PHY_DATA, 32'h00001234, "read data");
        chk(64'(nfr), 64'h2, "two frames");
        $display("phy test done");
        // full duplex pause frame and received pause
        bus(1'b1, IDX_AUX_CTRL, 32'h6);
        bus(1'b1, IDX_PAUSE_FLOW, 32'h00030007);
        rd(IDX_PAUSE_FLOW, 32'h00030006, "flow bits");
        chk(ptx.time_val, 16'h0003, "pause time");
        preq <= 1'b1;
        @(posedge ref_clk);
        preq <= 1'b0;
        rd(IDX_PAUSE_FLOW, 32'h00030007, "pause busy");
        pdone <= 1'b1;
        @(posedge ref_clk);
        pdone <= 1'b0;
        rd(IDX_PAUSE_FLOW, 32'h00030006, "busy clear");
        pause_rx(16'h0001);
        chk(pflag, 1'b1, "pause flag");
        n = 0;
        repeat (1400)
        begin
            @(posedge ref_clk);
            if (halt === 1'b1) n++;
        end
        chk(64'(n), 64'd1280, "halt length");
        // half duplex back pressure, then transmitter off
        bus(1'b1, IDX_AUX_CTRL, 32'h4);
        bpreq <= 1'b1;
        @(posedge ref_clk);
        rd(IDX_PAUSE_FLOW, 32'h00030007, "bp busy");
        bus(1'b1, IDX_AUX_CTRL, 32'h2);
        preq <= 1'b1;
        rd(IDX_PAUSE_FLOW, 32'h00030006, "tx off");
        chk({ptx.send, bp}, 2'b00, "tx off outputs");
        preq <= 1'b0;
        bpreq <= 1'b0;
        bus(1'b1, IDX_PAUSE_FLOW, 32'h00030000);
        pause_rx(16'h0001);
        chk(pflag, 1'b0, "no flag");
        repeat (3) @(posedge ref_clk);
        chk(halt, 1'b0, "no halt");
        $display("pause test done");
        give_verdict();
    end
endmodule : mac_hash_mii_flow_control_tb

// >>> verif/phy_mgmt_model.sv
// behavioural phy management register set answering 64-bit management frames
`timescale 1ns/1ps
module phy_mgmt_model
(
    input  wire  logic        mdc_in,
    input  wire  logic        mdio_in,
    output logic              mdio_out,
    output logic              mdio_oe_out,
    output logic [63:0]       frame_out,
    output int                nframes_out
);
    logic [15:0] regs [0:31];
    logic [63:0] sh = 64'h0;
    logic [15:0] dat = 16'h0;
    logic        rd = 1'b0;
    int          cnt = 0;
    // power-up contents, distinct per register
    initial
    begin
        mdio_out = 1'b0;
        mdio_oe_out = 1'b0;
        frame_out = 64'h0;
        nframes_out = 0;
        foreach (regs[i]) regs[i] = 16'hA500 + 16'(i);
    end
    // shift on rising clock, decode at bit 46 and at frame end
    always @(posedge mdc_in)
    begin
        sh = {sh[62:0], mdio_in};
        cnt = (cnt + 1) % 64;
        if (cnt == 46)
        begin
            rd = (sh[11:10] == 2'b10);
            dat = regs[sh[4:0]];
        end
        if (cnt == 0)
        begin
            frame_out = sh;
            nframes_out++;
            if (sh[29:28] == 2'b01) regs[sh[22:18]] = sh[15:0];
        end
    end
    // turnaround zero then data msb first on falling clock, released after
    always @(negedge mdc_in)
    begin
        mdio_oe_out = rd && cnt >= 46;
        mdio_out = (cnt >= 48) ? dat[63 - cnt] : 1'b0;
    end
endmodule : phy_mgmt_model
